// >>> hdl/irq_enable_flag.v
// interrupt enable and flag logic with APB register access
// assumes event inputs from on-chip logic on I_CLK are one-cycle pulses or levels as noted;
// the external interrupt pin and port-B pins are asynchronous and are synchronised here
`include "irq_enable_flag_map.vh"

module irq_enable_flag #(
  parameter PORTB_WIDTH = 8,
  parameter EXT_EDGE_RISING = 1
) (
  input wire I_CLK,
  input wire I_RSTN,
  input wire I_PSEL,
  input wire I_PENABLE,
  input wire I_PWRITE,
  input wire [11:0] I_PADDR,
  input wire [31:0] I_PWDATA,
  output reg [31:0] O_PRDATA,
  output reg O_PREADY,
  output reg O_PSLVERR,
  input wire I_EXT_PIN,
  input wire [PORTB_WIDTH-1:0] I_PORTB_PINS,
  input wire i_timer_zero_tick,
  input wire i_low_power_wakeup,
  input wire i_converter_done,
  input wire i_serial_rx_load,
  input wire [7:0] i_serial_rx_data,
  input wire i_serial_tx_taken,
  input wire i_sync_port_xfer_done,
  input wire i_sync_port_master,
  input wire i_sync_port_seq_done,
  input wire i_capcomp_one_event,
  input wire i_capcomp_one_pwm_mode,
  input wire i_timer_two_match,
  input wire i_timer_one_ovf,
  input wire [7:0] i_peripheral_request_two,
  output reg O_IRQ_REQUEST,
  output reg [7:0] O_SERIAL_TX_DATA,
  output reg O_SERIAL_TX_LOAD
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [7:0] core_ctrl_q;
  reg [7:0] core_ctrl_d;
  reg [7:0] peripheral_enable_one_q;
  reg [7:0] peripheral_enable_two_q;
  reg [7:0] peripheral_request_one_q;
  reg [7:0] peripheral_request_one_d;
  reg [PORTB_WIDTH-1:0] per_pin_change_select_q;
  reg [7:0] timer_zero_count_q;
  reg [7:0] serial_rx_data_q;
  reg rx_full_q;
  reg tx_empty_q;
  reg ext_prev_q;
  reg [PORTB_WIDTH-1:0] portb_prev_q;
  reg [2:0] sync_ready_q;
  reg portb_hit_q;
  reg portb_hit_d;

  wire ext_sync;
  wire [PORTB_WIDTH-1:0] portb_sync;
  wire wr_en;
  wire rd_en;
  wire ext_edge;
  wire [PORTB_WIDTH-1:0] portb_changed;
  wire portb_event;
  wire core_pending;
  wire periph_pending;
  reg [31:0] rd_data;
  reg addr_hit;
  reg [7:0] core_flags_d;
  wire portb_hit_event;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // address compare used for every register decode
  function is_addr;
    input [11:0] addr;
    input [11:0] target;
    begin
      is_addr = (addr == target);
    end
  endfunction

  // flag update: hardware set wins over a same-cycle software clear
  function [7:0] flag_merge;
    input [7:0] cur;
    input [7:0] set;
    input [7:0] wmask;
    input [7:0] wdata;
    input we;
    begin
      flag_merge = (we ? ((cur & ~wmask) | (wdata & wmask)) : cur) | set;
    end
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  pin_sync #(
    .WIDTH(PORTB_WIDTH + 1)
  ) u_pin_sync (
    .I_CLK(I_CLK),
    .I_RSTN(I_RSTN),
    .i_async({I_EXT_PIN, I_PORTB_PINS}),
    .o_sync({ext_sync, portb_sync})
  );

  // previous values for edge and change detection; detection waits three edges after reset
  // so that both samples hold real pin levels and a pin idling high gives no false edge
  always @(posedge I_CLK) begin
    if (!I_RSTN) begin
      ext_prev_q <= 1'b0;
      portb_prev_q <= {PORTB_WIDTH{1'b0}};
      sync_ready_q <= 3'h0;
    end else begin
      ext_prev_q <= ext_sync;
      portb_prev_q <= portb_sync;
      sync_ready_q <= {sync_ready_q[1:0], 1'b1};
    end
  end

  // edge of the external pin in the chosen direction
  assign ext_edge = sync_ready_q[2] &
                    ((EXT_EDGE_RISING != 0) ? (ext_sync & ~ext_prev_q) : (~ext_sync & ext_prev_q));
  // any port-B pin change, whatever its select bit
  assign portb_changed = sync_ready_q[2] ? (portb_sync ^ portb_prev_q) : {PORTB_WIDTH{1'b0}};
  assign portb_event = (|portb_changed) | i_low_power_wakeup;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // reads are taken in the first access cycle so data stands with pready;
  // writes land at the edge where pready is high
  assign wr_en = I_PSEL & I_PENABLE & I_PWRITE & O_PREADY;
  assign rd_en = I_PSEL & I_PENABLE & ~I_PWRITE & ~O_PREADY;

  // read mux; unimplemented bits read as zero
  always @* begin
    rd_data = 32'h00000000;
    addr_hit = 1'b1;
    if (is_addr(I_PADDR, `ADDR_CORE_INTERRUPT_CONTROL)) begin
      rd_data[7:0] = core_ctrl_q;
    end else if (is_addr(I_PADDR, `ADDR_PERIPHERAL_ENABLE_ONE)) begin
      rd_data[7:0] = peripheral_enable_one_q & `MASK_PERIPHERAL_ENABLE_ONE;
    end else if (is_addr(I_PADDR, `ADDR_PERIPHERAL_ENABLE_TWO)) begin
      rd_data[7:0] = peripheral_enable_two_q & `MASK_PERIPHERAL_ENABLE_TWO;
    end else if (is_addr(I_PADDR, `ADDR_PERIPHERAL_REQUEST_ONE)) begin
      rd_data[7:0] = {1'b0, peripheral_request_one_q[6:0]};
    end else if (is_addr(I_PADDR, `ADDR_PER_PIN_CHANGE_SELECT)) begin
      rd_data[PORTB_WIDTH-1:0] = per_pin_change_select_q;
    end else if (is_addr(I_PADDR, `ADDR_TIMER_ZERO_COUNT)) begin
      rd_data[7:0] = timer_zero_count_q;
    end else if (is_addr(I_PADDR, `ADDR_SERIAL_RX_DATA_REG)) begin
      rd_data[7:0] = serial_rx_data_q;
    end else if (is_addr(I_PADDR, `ADDR_SERIAL_TX_DATA_REG)) begin
      rd_data[7:0] = O_SERIAL_TX_DATA;
    end else begin
      addr_hit = 1'b0;
    end
  end

  // bus answer: access phase with one wait state, error on unmapped address
  always @(posedge I_CLK) begin
    if (!I_RSTN) begin
      O_PREADY <= 1'b0;
      O_PSLVERR <= 1'b0;
      O_PRDATA <= 32'h00000000;
    end else begin
      O_PREADY <= I_PSEL & I_PENABLE & ~O_PREADY;
      O_PSLVERR <= I_PSEL & I_PENABLE & ~O_PREADY & ~addr_hit;
      if (rd_en) begin
        O_PRDATA <= rd_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // core control register
  // ----------------------------------------------------------------
  // enables stored from writes, flags merged with hardware events
  always @* begin
    core_ctrl_d = core_ctrl_q;
    if (wr_en && is_addr(I_PADDR, `ADDR_CORE_INTERRUPT_CONTROL)) begin
      core_ctrl_d[7:3] = I_PWDATA[7:3];
    end
    core_flags_d = flag_merge({5'h00, core_ctrl_q[2:0]},
                              {5'h00, i_timer_zero_tick, ext_edge, portb_event},
                              8'h07, I_PWDATA[7:0],
                              wr_en & is_addr(I_PADDR, `ADDR_CORE_INTERRUPT_CONTROL));
    core_ctrl_d[2:0] = core_flags_d[2:0];
  end

  always @(posedge I_CLK) begin
    if (!I_RSTN) begin
      core_ctrl_q <= `RST_CORE_INTERRUPT_CONTROL;
    end else begin
      core_ctrl_q <= core_ctrl_d;
    end
  end

  // a change on a selected pin, an enabled wake-up or a software set arms the pin-change request
  assign portb_hit_event = (|(portb_changed & per_pin_change_select_q)) |
    (i_low_power_wakeup & peripheral_enable_two_q[2]) |
    (wr_en & is_addr(I_PADDR, `ADDR_CORE_INTERRUPT_CONTROL) & I_PWDATA[`BIT_PORTB_CHANGE_FLAG]);

  // armed bit falls with the flag when software clears it
  always @* begin
    portb_hit_d = core_ctrl_d[`BIT_PORTB_CHANGE_FLAG] & (portb_hit_q | portb_hit_event);
  end

  always @(posedge I_CLK) begin
    if (!I_RSTN) begin
      portb_hit_q <= 1'b0;
    end else begin
      portb_hit_q <= portb_hit_d;
    end
  end

  // ----------------------------------------------------------------
  // peripheral enables and pin select
  // ----------------------------------------------------------------
  always @(posedge I_CLK) begin
    if (!I_RSTN) begin
      peripheral_enable_one_q <= `RST_PERIPHERAL_ENABLE;
      peripheral_enable_two_q <= `RST_PERIPHERAL_ENABLE;
      per_pin_change_select_q <= {PORTB_WIDTH{1'b0}};
    end else if (wr_en) begin
      if (is_addr(I_PADDR, `ADDR_PERIPHERAL_ENABLE_ONE)) begin
        peripheral_enable_one_q <= I_PWDATA[7:0] & `MASK_PERIPHERAL_ENABLE_ONE;
      end
      if (is_addr(I_PADDR, `ADDR_PERIPHERAL_ENABLE_TWO)) begin
        peripheral_enable_two_q <= I_PWDATA[7:0] & `MASK_PERIPHERAL_ENABLE_TWO;
      end
      if (is_addr(I_PADDR, `ADDR_PER_PIN_CHANGE_SELECT)) begin
        per_pin_change_select_q <= I_PWDATA[PORTB_WIDTH-1:0];
      end
    end
  end

  // timer-0 count: only software and ticks touch it, reset leaves it alone
  always @(posedge I_CLK) begin
    if (wr_en && is_addr(I_PADDR, `ADDR_TIMER_ZERO_COUNT)) begin
      timer_zero_count_q <= I_PWDATA[7:0];
    end else if (i_timer_zero_tick) begin
      timer_zero_count_q <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // serial buffer status
  // ----------------------------------------------------------------
  // receive full until software reads data; transmit empty until software writes
  always @(posedge I_CLK) begin
    if (!I_RSTN) begin
      rx_full_q <= 1'b0;
      tx_empty_q <= 1'b1;
      serial_rx_data_q <= 8'h00;
      O_SERIAL_TX_DATA <= 8'h00;
      O_SERIAL_TX_LOAD <= 1'b0;
    end else begin
      O_SERIAL_TX_LOAD <= 1'b0;
      if (i_serial_rx_load) begin
        rx_full_q <= 1'b1;
        serial_rx_data_q <= i_serial_rx_data;
      end else if (rd_en && is_addr(I_PADDR, `ADDR_SERIAL_RX_DATA_REG)) begin
        rx_full_q <= 1'b0;
      end
      if (wr_en && is_addr(I_PADDR, `ADDR_SERIAL_TX_DATA_REG)) begin
        tx_empty_q <= 1'b0;
        O_SERIAL_TX_DATA <= I_PWDATA[7:0];
        O_SERIAL_TX_LOAD <= 1'b1;
      end else if (i_serial_tx_taken) begin
        tx_empty_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // peripheral request one
  // ----------------------------------------------------------------
  always @* begin
    peripheral_request_one_d = flag_merge(peripheral_request_one_q,
      {1'b0,
       i_converter_done,
       2'b00,
       i_sync_port_xfer_done | (i_sync_port_master & i_sync_port_seq_done),
       i_capcomp_one_event & ~i_capcomp_one_pwm_mode,
       i_timer_two_match,
       i_timer_one_ovf},
      `MASK_REQUEST_ONE_WRITABLE, I_PWDATA[7:0],
      wr_en & is_addr(I_PADDR, `ADDR_PERIPHERAL_REQUEST_ONE));
    // read-only buffer flags and the always-zero top bit
    peripheral_request_one_d[`BIT_SERIAL_RX_FULL_FLAG] = rx_full_q;
    peripheral_request_one_d[`BIT_SERIAL_TX_EMPTY_FLAG] = tx_empty_q;
    peripheral_request_one_d[7] = 1'b0;
  end

  always @(posedge I_CLK) begin
    if (!I_RSTN) begin
      peripheral_request_one_q <= `RST_PERIPHERAL_REQUEST_ONE;
    end else begin
      peripheral_request_one_q <= peripheral_request_one_d;
    end
  end

  // ----------------------------------------------------------------
  // request to the core
  // ----------------------------------------------------------------
  // pin-change path needs the enable and a change on a selected pin, an enabled wake-up or a software set
  assign core_pending =
    (core_ctrl_q[`BIT_TIMER_ZERO_OVF_ENABLE] & core_ctrl_q[`BIT_TIMER_ZERO_OVF_FLAG]) |
    (core_ctrl_q[`BIT_EXT_PIN_IRQ_ENABLE] & core_ctrl_q[`BIT_EXT_PIN_IRQ_FLAG]) |
    (core_ctrl_q[`BIT_PORTB_CHANGE_ENABLE] & core_ctrl_q[`BIT_PORTB_CHANGE_FLAG] & portb_hit_q);
  assign periph_pending = core_ctrl_q[`BIT_PERIPHERAL_IRQ_GATE] &
    ((|(peripheral_enable_one_q & peripheral_request_one_q & `MASK_PERIPHERAL_ENABLE_ONE)) |
     (|(peripheral_enable_two_q & i_peripheral_request_two & `MASK_PERIPHERAL_ENABLE_TWO)));

  always @(posedge I_CLK) begin
    if (!I_RSTN) begin
      O_IRQ_REQUEST <= 1'b0;
    end else begin
      O_IRQ_REQUEST <= core_ctrl_q[`BIT_GLOBAL_IRQ_ENABLE] & (core_pending | periph_pending);
    end
  end
endmodule // irq_enable_flag

// >>> hdl/irq_enable_flag_map.vh
// register map, field positions and reset values of the interrupt enable and flag block
// assumes an APB slave with 32-bit data, one aligned word per register
`ifndef IRQ_ENABLE_FLAG_MAP_VH
`define IRQ_ENABLE_FLAG_MAP_VH
// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define ADDR_CORE_INTERRUPT_CONTROL 12'h000
`define ADDR_PERIPHERAL_ENABLE_ONE 12'h004
`define ADDR_PERIPHERAL_ENABLE_TWO 12'h008
`define ADDR_PERIPHERAL_REQUEST_ONE 12'h00C
`define ADDR_PER_PIN_CHANGE_SELECT 12'h010
`define ADDR_TIMER_ZERO_COUNT 12'h014
`define ADDR_SERIAL_RX_DATA_REG 12'h018
`define ADDR_SERIAL_TX_DATA_REG 12'h01C
// ----------------------------------------------------------------
// core control fields
// ----------------------------------------------------------------
`define BIT_GLOBAL_IRQ_ENABLE 7
`define BIT_PERIPHERAL_IRQ_GATE 6
`define BIT_TIMER_ZERO_OVF_ENABLE 5
`define BIT_EXT_PIN_IRQ_ENABLE 4
`define BIT_PORTB_CHANGE_ENABLE 3
`define BIT_TIMER_ZERO_OVF_FLAG 2
`define BIT_EXT_PIN_IRQ_FLAG 1
`define BIT_PORTB_CHANGE_FLAG 0
// ----------------------------------------------------------------
// peripheral request one fields
// ----------------------------------------------------------------
`define BIT_CONVERTER_DONE_FLAG 6
`define BIT_SERIAL_RX_FULL_FLAG 5
`define BIT_SERIAL_TX_EMPTY_FLAG 4
`define BIT_SYNC_PORT_EVENT_FLAG 3
`define BIT_CAPCOMP_ONE_FLAG 2
`define BIT_TIMER_TWO_MATCH_FLAG 1
`define BIT_TIMER_ONE_OVF_FLAG 0
// ----------------------------------------------------------------
// implemented-bit masks and reset values
// ----------------------------------------------------------------
`define MASK_PERIPHERAL_ENABLE_ONE 8'h7F
`define MASK_PERIPHERAL_ENABLE_TWO 8'hFD
`define MASK_REQUEST_ONE_WRITABLE 8'h4F
`define RST_CORE_INTERRUPT_CONTROL 8'h00
`define RST_PERIPHERAL_ENABLE 8'h00
`define RST_PERIPHERAL_REQUEST_ONE 8'h00
`define RST_PER_PIN_CHANGE_SELECT 8'h00
`endif

// >>> hdl/pin_sync.v
// two-flop synchroniser for a vector of asynchronous pins
// assumes one clock; the first stage is read only by the second stage
module pin_sync #(
  parameter WIDTH = 8
) (
  input wire I_CLK,
  input wire I_RSTN,
  input wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  // two stages, cleared by the synchronous reset
  always @(posedge I_CLK) begin
    if (!I_RSTN) begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;
endmodule // pin_sync

// >>> bench/irq_source_model.sv
// far-side model: on-chip event sources and the external and port-B pins
// assumes the bench raises one bit of i_fire for one clock per event
module irq_source_model (
  input wire logic I_CLK,
  input wire logic [11:0] i_fire,
  output logic o_ext_pin,
  output logic [7:0] o_portb_pins,
  output logic [11:0] o_pulse
);
  // pins start low so the first fire gives a rising edge
  initial begin
    o_ext_pin = 1'h0;
    o_portb_pins = 8'h00;
    o_pulse = 12'h000;
  end
  // one-cycle pulses; a pin toggles so each fire is exactly one change
  always @(posedge I_CLK) begin
    o_pulse <= i_fire;
    if (i_fire[1]) o_ext_pin <= ~o_ext_pin;
    if (i_fire[8]) o_portb_pins[0] <= ~o_portb_pins[0];
  end
endmodule // irq_source_model

// >>> bench/irq_enable_flag_chk.sv
// checker on the top-level ports of the interrupt enable and flag block
// assumes one clock and a synchronous active-low reset
module irq_enable_flag_chk (
  input wire logic I_CLK,
  input wire logic I_RSTN,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [31:0] O_PRDATA,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  input wire logic O_IRQ_REQUEST,
  input wire logic [7:0] O_SERIAL_TX_DATA,
  input wire logic O_SERIAL_TX_LOAD
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RSTN);
  logic gie_q;
  logic [7:0] txd_q;
  // shadow of the global enable and of the last transmit byte
  always @(posedge I_CLK) begin
    if (!I_RSTN) begin
      gie_q <= 1'h0;
      txd_q <= 8'h00;
    end else begin
      if (I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && I_PADDR == 12'h000) gie_q <= I_PWDATA[7];
      if (I_PSEL && I_PENABLE && I_PWRITE && I_PADDR == 12'h01C) txd_q <= I_PWDATA[7:0];
    end
  end
  sequence s_access;
    I_PSEL && I_PENABLE && !O_PREADY;
  endsequence
  sequence s_tx_write;
    I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && I_PADDR == 12'h01C;
  endsequence
  sequence s_gie_off;
    !gie_q && !(I_PSEL && I_PENABLE && I_PWRITE && I_PADDR == 12'h000 && I_PWDATA[7]);
  endsequence
  a_ready_after_access: assert property (s_access |=> O_PREADY)
    else $error("ready missing after access phase");
  a_ready_one_cycle: assert property (O_PREADY |=> !O_PREADY)
    else $error("ready longer than one cycle");
  a_ready_needs_access: assert property (O_PREADY |-> $past(I_PSEL && I_PENABLE))
    else $error("ready without access phase");
  a_slverr_on_unmapped: assert property (O_PREADY |-> O_PSLVERR == (I_PADDR[11:5] != 7'h00 || I_PADDR[1:0] != 2'h0))
    else $error("error response does not match address");
  a_rdata_upper_zero: assert property (O_PREADY && !I_PWRITE |-> O_PRDATA[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  a_global_blocks: assert property (s_gie_off |=> !O_IRQ_REQUEST)
    else $error("request raised with global enable off");
  a_tx_load_write: assert property (s_tx_write |-> ##[0:2] O_SERIAL_TX_LOAD)
    else $error("no transmit load after transmit write");
  a_tx_load_pulse: assert property (O_SERIAL_TX_LOAD |=> !O_SERIAL_TX_LOAD)
    else $error("transmit load longer than one cycle");
  a_tx_load_data: assert property ($rose(O_SERIAL_TX_LOAD) |-> O_SERIAL_TX_DATA == txd_q)
    else $error("transmit data differs from written byte");
endmodule // irq_enable_flag_chk

bind irq_enable_flag irq_enable_flag_chk chk_u (.I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_PSEL(I_PSEL),
  .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA),
  .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_IRQ_REQUEST(O_IRQ_REQUEST),
  .O_SERIAL_TX_DATA(O_SERIAL_TX_DATA), .O_SERIAL_TX_LOAD(O_SERIAL_TX_LOAD));

// >>> bench/mcu_interrupt_enable_flag_logic_tb.sv
// self-checking bench for the interrupt enable and flag block
// assumes the event model in irq_source_model and the bound port checker
module mcu_interrupt_enable_flag_logic_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [11:0] en_a; logic [7:0] en_v; logic [7:0] core_v; logic [2:0] lvl;
    logic [3:0] idx; logic [11:0] flag_a; logic [7:0] flag_v; logic irq;
  } row_t;
  row_t rows [17];
  logic clk, rstn, psel, penable, pwrite, master, pwm;
  logic [11:0] paddr, fire_q, a;
  logic [31:0] pwdata;
  logic [7:0] req2, rv;
  logic ev;
  wire [31:0] prdata;
  wire pready, pslverr, irq, ext_pin, txl;
  wire [7:0] pins, txd;
  wire [11:0] pulse;
  int failures, comparisons;
  irq_enable_flag dut_u (.I_CLK(clk), .I_RSTN(rstn), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_EXT_PIN(ext_pin), .I_PORTB_PINS(pins), .i_timer_zero_tick(pulse[0]), .i_low_power_wakeup(pulse[2]),
    .i_converter_done(pulse[3]), .i_serial_rx_load(pulse[10]), .i_serial_rx_data(8'hA5),
    .i_serial_tx_taken(pulse[11]), .i_sync_port_xfer_done(pulse[4]), .i_sync_port_master(master),
    .i_sync_port_seq_done(pulse[9]), .i_capcomp_one_event(pulse[5]), .i_capcomp_one_pwm_mode(pwm),
    .i_timer_two_match(pulse[6]), .i_timer_one_ovf(pulse[7]), .i_peripheral_request_two(req2),
    .O_IRQ_REQUEST(irq), .O_SERIAL_TX_DATA(txd), .O_SERIAL_TX_LOAD(txl));
  irq_source_model model_u (.I_CLK(clk), .i_fire(fire_q), .o_ext_pin(ext_pin), .o_portb_pins(pins),
    .o_pulse(pulse));
  // 20 MHz clock
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task stop_test();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // one APB transfer: setup, access, hold until ready is sampled high
  task apb(input logic w, input logic [11:0] ad, input logic [7:0] d, output logic [7:0] r, output logic e);
    int n;
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n = n + 1;
    end while (pready !== 1'h1 && n < 16);
    check(pready, 1'h1);
    r = prdata[7:0];
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task wr(input logic [11:0] ad, input logic [7:0] d);
    logic [7:0] r;
    logic e;
    apb(1'h1, ad, d, r, e);
  endtask
  task rd(input logic [11:0] ad, output logic [7:0] r);
    logic e;
    apb(1'h0, ad, 8'h00, r, e);
  endtask
  task fire(input logic [3:0] i);
    @(posedge clk);
    fire_q <= 12'h001 << i;
    @(posedge clk);
    fire_q <= 12'h000;
  endtask
  task do_reset();
    rstn <= 1'h0;
    repeat (8) @(posedge clk);
    rstn <= 1'h1;
  endtask
  // one row: clear the registers at 000 to 010, enable, raise the event, check request and flag, clear
  task run_row(input row_t r);
    for (a = 12'h000; a <= 12'h010; a = a + 12'h004) wr(a, 8'h00);
    {req2[7], pwm, master} <= r.lvl;
    wr(r.en_a, r.en_v);
    wr(12'h000, r.core_v);
    fire(r.idx);
    repeat (8) @(posedge clk);
    check(irq, r.irq);
    rd(r.flag_a, rv);
    check(rv, r.flag_v);
    wr(r.flag_a, 8'h00);
    repeat (3) @(posedge clk);
    check(irq, 1'h0);
    {req2[7], pwm, master} <= 3'h0;
  endtask
  // watchdog
  initial begin
    #(50 * 8000);
    failures = failures + 1;
    stop_test();
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, master, pwm, rstn} = 6'h00;
    {paddr, fire_q, pwdata, req2} = 64'h0;
    failures = 0;
    comparisons = 0;
    rows = '{'{12'h000, 8'h00, 8'hA0, 3'h0, 4'h0, 12'h000, 8'hA4, 1'h1},
      '{12'h000, 8'h00, 8'h20, 3'h0, 4'h0, 12'h000, 8'h24, 1'h0},
      '{12'h000, 8'h00, 8'h90, 3'h0, 4'h1, 12'h000, 8'h92, 1'h1},
      '{12'h010, 8'h00, 8'h88, 3'h0, 4'h8, 12'h000, 8'h89, 1'h0},
      '{12'h010, 8'h01, 8'h88, 3'h0, 4'h8, 12'h000, 8'h89, 1'h1},
      '{12'h008, 8'h04, 8'h88, 3'h0, 4'h2, 12'h000, 8'h89, 1'h1},
      '{12'h004, 8'h40, 8'hC0, 3'h0, 4'h3, 12'h00C, 8'h50, 1'h1},
      '{12'h004, 8'h40, 8'h80, 3'h0, 4'h3, 12'h00C, 8'h50, 1'h0},
      '{12'h004, 8'h08, 8'hC0, 3'h0, 4'h4, 12'h00C, 8'h18, 1'h1},
      '{12'h004, 8'h08, 8'hC0, 3'h0, 4'h9, 12'h00C, 8'h10, 1'h0},
      '{12'h004, 8'h08, 8'hC0, 3'h1, 4'h9, 12'h00C, 8'h18, 1'h1},
      '{12'h004, 8'h04, 8'hC0, 3'h0, 4'h5, 12'h00C, 8'h14, 1'h1},
      '{12'h004, 8'h04, 8'hC0, 3'h2, 4'h5, 12'h00C, 8'h10, 1'h0},
      '{12'h004, 8'h02, 8'hC0, 3'h0, 4'h6, 12'h00C, 8'h12, 1'h1},
      '{12'h004, 8'h01, 8'hC0, 3'h0, 4'h7, 12'h00C, 8'h11, 1'h1},
      '{12'h008, 8'h80, 8'hC0, 3'h4, 4'hF, 12'h008, 8'h80, 1'h1},
      '{12'h010, 8'h02, 8'h88, 3'h0, 4'h8, 12'h000, 8'h89, 1'h0}};
    do_reset();
    for (int k = 0; k < 17; k++) run_row(rows[k]);
    // reset values and implemented bits
    do_reset();
    for (a = 12'h000; a <= 12'h010; a = a + 12'h004) begin
      rd(a, rv);
      check(rv, (a == 12'h00C) ? 8'h10 : 8'h00);
    end
    wr(12'h004, 8'hFF);
    rd(12'h004, rv);
    check(rv, 8'h7F);
    wr(12'h008, 8'hFF);
    rd(12'h008, rv);
    check(rv, 8'hFD);
    wr(12'h00C, 8'hFF);
    rd(12'h00C, rv);
    check(rv, 8'h5F);
    apb(1'h0, 12'h020, 8'h00, rv, ev);
    check(ev, 1'h1);
    // receive flag follows the buffer and clears on a data read
    wr(12'h00C, 8'h00);
    wr(12'h004, 8'h20);
    wr(12'h000, 8'hC0);
    fire(4'hA);
    repeat (4) @(posedge clk);
    check(irq, 1'h1);
    rd(12'h00C, rv);
    check(rv, 8'h30);
    rd(12'h018, rv);
    check(rv, 8'hA5);
    rd(12'h00C, rv);
    check(rv, 8'h10);
    // transmit flag clears on a data write and sets when the buffer empties
    wr(12'h01C, 8'h3C);
    rd(12'h00C, rv);
    check(rv, 8'h00);
    check(txd, 8'h3C);
    fire(4'hB);
    repeat (3) @(posedge clk);
    rd(12'h00C, rv);
    check(rv, 8'h10);
    // flag written by software requests like an event
    wr(12'h000, 8'hA4);
    repeat (3) @(posedge clk);
    check(irq, 1'h1);
    // timer-0 count survives reset
    wr(12'h014, 8'h5A);
    do_reset();
    rd(12'h014, rv);
    check(rv, 8'h5A);
    rd(12'h000, rv);
    check(rv, 8'h00);
    stop_test();
  end
endmodule // mcu_interrupt_enable_flag_logic_tb
